/* hw/sdsg_gating.sv */
`timescale 1ns/1ps
// Summary of operation
// R1: after main drive falls, sync drive stays off for the first dead time.
// R2: after dead time, sync turns on only if zero current sense exceeds arm threshold.
// R3: an armed sync pulse lasts until zero current sense drops below trigger threshold.
// R4: in critical/discontinuous mode, no new main pulse before the trigger crossing.
// R5: in continuous mode, sync ends second dead time before next period starts.
// R6: sync pulses withheld until line sense has crossed its threshold.
// R7: sync pulses allowed only while regulation good flag is set.
// R8: skip entered only on external command pulses on either pin.
// R9: a command counts only if the pin stays low longer than minimum width.
// R10: the outside party repeats commands faster than the burst frequency.
// R11: in skip, drives and all but feedback and supply monitoring are off.
// R12: at 94 percent output, leave skip for a burst until nominal is restored.
// R13: with commands still arriving, skip, burst, skip repeats without limit.
// R14: regulation good output high in nominal operation, low at startup or fault.
// R15: regulation good held low until feedback reaches 98 percent of reference.
// R16: sync and slow leg rectifier drives fully off until regulation first reached.
// R17: no skip entry nor bulk undervoltage fault before flag first set.
// R18: main drive and sync drive never asserted together.
module sdsg_gating (
  // clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_b,
  // drive requests from the modulator
  input  wire logic                       i_main_drive_req,
  input  wire logic                       i_slow_leg_req,
  input  wire logic                       i_ccm_mode,
  // oscillator period framing
  input  wire logic                       i_period_start,
  input  wire logic [sdsg_pkg::PER_W-1:0] i_period_len,
  // comparator results
  input  wire logic                       i_zero_current_above_arm,
  input  wire logic                       i_zero_current_above_trig,
  input  wire logic                       i_line_above_sync,
  input  wire logic                       i_fb_above_regok,
  input  wire logic                       i_fb_below_skip_exit,
  input  wire logic                       i_fb_at_nominal,
  input  wire logic                       i_fb_below_bulk_uv,
  input  wire logic                       i_fault,
  // skip command pins, below skip_command_threshold
  input  wire logic                       i_regulation_good_low,
  input  wire logic                       i_modulation_pin_low,
  // drives
  output logic                            o_main_drive,
  output logic                            o_sync_drive,
  output logic                            o_slow_leg_rectifier_drive,
  // status
  output logic                            o_regulation_good,
  output logic                            o_regulation_good_flag,
  output logic                            o_skip_active,
  output logic                            o_burst_active,
  output logic                            o_low_power,
  output logic                            o_bulk_undervoltage_fault
);

  typedef struct packed {
    sdsg_pkg::sdsg_sync_state_type    sy;
    sdsg_pkg::sdsg_skip_state_type    sk;
    logic [sdsg_pkg::DT_CNT_W-1:0]    dt_cnt;
    logic [sdsg_pkg::PER_W-1:0]       per_cnt;
    logic                             crossed;
    logic                             cmd_seen;
    logic                             flag;
    logic                             main;
    logic                             sync;
    logic                             slow;
    logic                             regok;
    logic                             bulk_uv;
    logic                             skip;
    logic                             burst;
    logic                             low_pwr;
  } sdsg_state_type;

  localparam logic [sdsg_pkg::DT_CNT_W-1:0] DT1_LAST =
    sdsg_pkg::DT_CNT_W'(sdsg_pkg::DT1_CYCLES - 1);
  localparam logic [sdsg_pkg::PER_W:0] DT2_LEAD =
    (sdsg_pkg::PER_W + 1)'(sdsg_pkg::DT2_CYCLES);
  localparam int CHK_DT1 = sdsg_pkg::DT1_CYCLES;

  // saturating increment, used only by the period counter
  function automatic logic [sdsg_pkg::PER_W-1:0] sat_inc(
    input logic [sdsg_pkg::PER_W-1:0] v
  );
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // reset release through two flops
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // qualified command pulses from either pin
  logic cmd_regok;
  logic cmd_mod;

  sdsg_skip_qualifier u_qual_regok (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (rst_sync),
    .i_pin_low (i_regulation_good_low),
    .o_cmd     (cmd_regok)
  );

  sdsg_skip_qualifier u_qual_mod (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (rst_sync),
    .i_pin_low (i_modulation_pin_low),
    .o_cmd     (cmd_mod)
  );

  sdsg_state_type s;
  sdsg_state_type next_s;
  logic           cmd_any;
  logic           drives_en;
  logic           sync_en;
  logic           period_late;
  logic           main_ok;

  assign cmd_any = cmd_regok | cmd_mod; // R8

  // drive permissions; skip sheds everything but the monitors
  assign drives_en = s.flag & ~s.skip & ~i_fault; // R11 R16
  assign sync_en   = drives_en & i_line_above_sync; // R6 R7
  // sync must be gone one lead time before the oscillator restarts
  assign period_late = ({1'b0, s.per_cnt} + DT2_LEAD) >= {1'b0, i_period_len};
  // a fresh main pulse in critical mode waits for the trigger crossing
  assign main_ok = s.main | i_ccm_mode | s.crossed; // R4

  always_comb begin
    next_s = s;

    // regulation flag is set once and held until reset
    if (i_fb_above_regok) begin
      next_s.flag = 1'b1; // R15
    end

    // oscillator period position
    if (i_period_start) begin
      next_s.per_cnt = '0;
    end else begin
      next_s.per_cnt = sat_inc(s.per_cnt);
    end

    // main drive: blocked while sync is on or still held
    next_s.main = i_main_drive_req & drives_en & main_ok
                  & ~s.sync & (s.sy != sdsg_pkg::SY_ON); // R18 R4

    // trigger crossing memory, cleared by each main pulse
    if (s.main) begin
      next_s.crossed = 1'b0;
    end else if (!i_zero_current_above_trig) begin
      next_s.crossed = 1'b1;
    end

    // sync sequence
    next_s.dt_cnt = '0;
    case (s.sy)
      sdsg_pkg::SY_IDLE: begin
        if (!s.main) begin
          next_s.sy = sdsg_pkg::SY_DEAD1;
        end
      end
      sdsg_pkg::SY_DEAD1: begin
        next_s.dt_cnt = s.dt_cnt + 1'b1;
        if (s.main) begin
          next_s.sy = sdsg_pkg::SY_IDLE;
        end else if (s.dt_cnt == DT1_LAST) begin
          next_s.sy = sdsg_pkg::SY_ARM; // R1
        end
      end
      sdsg_pkg::SY_ARM: begin
        if (s.main || i_main_drive_req) begin
          next_s.sy = sdsg_pkg::SY_IDLE; // R2
        end else if (i_zero_current_above_arm && sync_en && i_zero_current_above_trig
                     && !(i_ccm_mode && period_late)) begin
          next_s.sy = sdsg_pkg::SY_ON; // R2
        end
      end
      sdsg_pkg::SY_ON: begin
        if (!i_zero_current_above_trig) begin
          next_s.sy = sdsg_pkg::SY_DONE; // R3 R4
        end else if (i_ccm_mode && period_late) begin
          next_s.sy = sdsg_pkg::SY_DONE; // R5
        end else if (!sync_en) begin
          next_s.sy = sdsg_pkg::SY_DONE;
        end
      end
      sdsg_pkg::SY_DONE: begin
        if (s.main) begin
          next_s.sy = sdsg_pkg::SY_IDLE;
        end
      end
      default: begin
        next_s.sy = sdsg_pkg::SY_IDLE;
      end
    endcase

    // sync output follows the sequence, never beside main
    next_s.sync = (next_s.sy == sdsg_pkg::SY_ON) & ~next_s.main & ~s.main; // R18

    // slow leg drive waits for the regulation flag
    next_s.slow = i_slow_leg_req & drives_en; // R16

    // command memory: a new command beats the clear on skip entry
    next_s.cmd_seen = s.cmd_seen;
    if (next_s.sk == sdsg_pkg::SK_SKIP && s.sk != sdsg_pkg::SK_SKIP) begin
      next_s.cmd_seen = 1'b0;
    end
    if (cmd_any) begin
      next_s.cmd_seen = 1'b1; // R8
    end

    // skip, burst, skip
    case (s.sk)
      sdsg_pkg::SK_RUN: begin
        if (s.cmd_seen && s.flag && !i_fault) begin
          next_s.sk       = sdsg_pkg::SK_SKIP; // R17
          next_s.cmd_seen = cmd_any;
        end
      end
      sdsg_pkg::SK_SKIP: begin
        if (i_fb_below_skip_exit) begin
          next_s.sk = sdsg_pkg::SK_BURST; // R12
        end
      end
      sdsg_pkg::SK_BURST: begin
        if (i_fb_at_nominal) begin
          // R13: stay in the loop only while commands keep coming
          if (s.cmd_seen) begin
            next_s.sk       = sdsg_pkg::SK_SKIP; // R13
            next_s.cmd_seen = cmd_any;
          end else begin
            next_s.sk = sdsg_pkg::SK_RUN;
          end
        end
      end
      default: begin
        next_s.sk = sdsg_pkg::SK_RUN;
      end
    endcase

    next_s.skip    = (next_s.sk == sdsg_pkg::SK_SKIP); // R11
    next_s.burst   = (next_s.sk == sdsg_pkg::SK_BURST);
    next_s.low_pwr = next_s.skip; // R11
    // pin stays high through skip so the downstream stage keeps running
    next_s.regok   = next_s.flag & ~i_fault; // R14 R15
    next_s.bulk_uv = s.flag & i_fb_below_bulk_uv; // R17

    // skip entry sheds the drives on the same edge, not one cycle late
    if (next_s.skip) begin
      next_s.main = 1'b0; // R11
      next_s.sync = 1'b0; // R11
      next_s.slow = 1'b0; // R11
    end
  end

  // whole state registered on every edge
  always_ff @(posedge i_sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      s      <= '0;
      s.flag <= sdsg_pkg::RST_FLAG;
      s.main <= sdsg_pkg::RST_DRIVE;
      s.sync <= sdsg_pkg::RST_DRIVE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign o_main_drive               = s.main;
  assign o_sync_drive               = s.sync;
  assign o_slow_leg_rectifier_drive = s.slow;
  assign o_regulation_good          = s.regok;
  assign o_regulation_good_flag     = s.flag;
  assign o_skip_active              = s.skip;
  assign o_burst_active             = s.burst;
  assign o_low_power                = s.low_pwr;
  assign o_bulk_undervoltage_fault  = s.bulk_uv;

  // checker helper: cycles since main drive was last high
  logic [sdsg_pkg::OFF_CNT_W-1:0] main_off_cnt;

  always_ff @(posedge i_sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      main_off_cnt <= '0;
    end else if (s.main) begin
      main_off_cnt <= '0;
    end else if (!(&main_off_cnt)) begin
      main_off_cnt <= main_off_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_sync);

  chk_drive_no_overlap: assert property (!(o_main_drive && o_sync_drive)) // R18
    else $error("main and sync drive high together");

  chk_first_dead_time: assert property (o_sync_drive |-> main_off_cnt >= CHK_DT1) // R1
    else $error("sync drive inside first dead time");

  chk_sync_arm_seen: assert property ($rose(o_sync_drive) // R2
    |-> $past(i_zero_current_above_arm, 1))
    else $error("sync started without arm threshold");

  chk_sync_trig_end: assert property (o_sync_drive && !i_zero_current_above_trig // R3
    |=> !o_sync_drive)
    else $error("sync held past trigger crossing");

  chk_crm_main_wait: assert property ($rose(o_main_drive) && !$past(i_ccm_mode)
    |-> $past(s.crossed)) // R4
    else $error("main pulse before trigger crossing");

  chk_ccm_dt2_cut: assert property (i_ccm_mode && period_late |=> !o_sync_drive) // R5
    else $error("sync still on inside second dead time");

  chk_sync_line_gate: assert property ($rose(o_sync_drive) |-> $past(i_line_above_sync)) // R6
    else $error("sync while line below threshold");

  chk_sync_flag_gate: assert property (o_sync_drive |-> o_regulation_good_flag) // R7
    else $error("sync before regulation good flag");

  chk_skip_drives_off: assert property (o_skip_active
    |-> !o_main_drive && !o_sync_drive && !o_slow_leg_rectifier_drive && o_low_power) // R11
    else $error("drive active during skip");

  chk_skip_burst_exit: assert property (o_skip_active && i_fb_below_skip_exit
    |=> o_burst_active) // R12
    else $error("no burst at low output");

  chk_regok_low_start: assert property (!o_regulation_good_flag |-> !o_regulation_good) // R15
    else $error("regulation good high before flag");

  chk_regok_fault: assert property (i_fault |=> !o_regulation_good) // R14
    else $error("regulation good high during fault");

  chk_slow_leg_gate: assert property (o_slow_leg_rectifier_drive
    |-> $past(o_regulation_good_flag)) // R16
    else $error("slow leg drive before regulation");

  chk_skip_need_flag: assert property ($rose(o_skip_active) |-> $past(o_regulation_good_flag)
    && $past(s.cmd_seen)) // R17 R8
    else $error("skip entered without flag or command");

  chk_bulk_uv_flag: assert property (o_bulk_undervoltage_fault |-> o_regulation_good_flag) // R17
    else $error("bulk undervoltage before flag");

  cov_sync_pulse: cover property ($rose(o_sync_drive) ##[1:200] $fell(o_sync_drive));
  cov_ccm_cut: cover property (i_ccm_mode && o_sync_drive && period_late);
  cov_skip_loop: cover property ($rose(o_burst_active) ##[1:1000] $rose(o_skip_active));
  cov_regok_rise: cover property ($rose(o_regulation_good));

endmodule

/* hw/sdsg_pkg.sv */
package sdsg_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DT1_NS         = 130;
  localparam int DT2_NS         = 150;
  localparam int SKIP_MIN_US    = 30;
  // least times round up to whole cycles
  localparam int DT1_CYCLES     = (DT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DT2_CYCLES     = (DT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SKIP_MIN_CYCLES = (SKIP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter widths
  localparam int DT_CNT_W   = 4;
  localparam int PER_W      = 16;
  localparam int SKIP_CNT_W = 12;
  localparam int OFF_CNT_W  = 5;

  // reset values
  localparam logic RST_FLAG   = 1'b0;
  localparam logic RST_DRIVE  = 1'b0;

  // sync drive sequence
  typedef enum logic [2:0] {
    SY_IDLE,
    SY_DEAD1,
    SY_ARM,
    SY_ON,
    SY_DONE
  } sdsg_sync_state_type;

  // skip / burst sequence
  typedef enum logic [1:0] {
    SK_RUN,
    SK_SKIP,
    SK_BURST
  } sdsg_skip_state_type;

endpackage

/* hw/sdsg_skip_qualifier.sv */
`timescale 1ns/1ps
module sdsg_skip_qualifier (
  // clock and synchronised reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  // comparator: pin below skip_command_threshold
  input  wire logic i_pin_low,
  // one-cycle pulse for each qualified command
  output logic      o_cmd
);

  typedef struct packed {
    logic [sdsg_pkg::SKIP_CNT_W-1:0] cnt;
    logic                             fired;
    logic                             cmd;
  } sdsg_qual_state_type;

  localparam logic [sdsg_pkg::SKIP_CNT_W-1:0] MIN_W =
    sdsg_pkg::SKIP_CNT_W'(sdsg_pkg::SKIP_MIN_CYCLES);
  localparam int CHK_MIN = sdsg_pkg::SKIP_MIN_CYCLES;

  sdsg_qual_state_type s;
  sdsg_qual_state_type next_s;

  // count low time; fire once, only when strictly longer than the minimum
  always_comb begin
    next_s     = s;
    next_s.cmd = 1'b0;
    if (!i_pin_low) begin
      next_s.cnt   = '0;
      next_s.fired = 1'b0;
    end else if (s.cnt != MIN_W) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (!s.fired) begin
      next_s.cmd   = 1'b1; // R9
      next_s.fired = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_cmd = s.cmd;

  // a command only follows a full minimum-width low period
  chk_cmd_width_min: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // R9
    $rose(o_cmd) |-> $past(s.cnt) == CHK_MIN && $past(i_pin_low))
    else $error("skip command issued before minimum width");

endmodule

/* tb/sdsg_downstream_model.sv */
`timescale 1ns/1ps
module sdsg_downstream_model (
  // clock
  input  wire logic        i_sys_clk,
  // pulse train control from the bench
  input  wire logic        i_keep,
  input  wire logic [15:0] i_width,
  input  wire logic [15:0] i_gap,
  // pin pulled below skip_command_threshold
  output logic             o_pin_low
);
  int cnt = 0;

  // pin idles released at time zero
  initial o_pin_low = 1'h0;

  // low for i_width cycles, released for i_gap; a started pulse always completes
  // a released pin returns high through its pull-up, so no stale low is left
  // updated on the edge itself, so bench changes just after an edge never race it
  always @(posedge i_sys_clk) begin
    if (cnt != 0 || i_keep) begin
      o_pin_low <= (cnt < int'(i_width));
      cnt <= (cnt + 1 >= int'(i_width) + int'(i_gap)) ? 0 : cnt + 1;
    end else begin
      o_pin_low <= 1'h0;
    end
  end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        clk, rst_b, main_req, slow_req, ccm, per_start, zarm, ztrig, line_ok;
  logic        fb_ok, fb_exit, fb_nom, fb_low_bulk, fault, mod_low, keep, pin_low;
  logic        main_drv, sync_drv, slow_drv, rg, rg_flag, skip, burst, low_pwr, bulk_uv;
  logic        sync_q;
  logic [15:0] per_len, width, gap;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          main_low = 0;
  int          ncyc = 0;
  int          n, dly, t0;

  sdsg_gating dut_u (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_main_drive_req(main_req),
    .i_slow_leg_req(slow_req), .i_ccm_mode(ccm), .i_period_start(per_start),
    .i_period_len(per_len), .i_zero_current_above_arm(zarm),
    .i_zero_current_above_trig(ztrig), .i_line_above_sync(line_ok), .i_fb_above_regok(fb_ok),
    .i_fb_below_skip_exit(fb_exit), .i_fb_at_nominal(fb_nom), .i_fb_below_bulk_uv(fb_low_bulk),
    .i_fault(fault), .i_regulation_good_low(pin_low), .i_modulation_pin_low(mod_low),
    .o_main_drive(main_drv), .o_sync_drive(sync_drv),
    .o_slow_leg_rectifier_drive(slow_drv), .o_regulation_good(rg),
    .o_regulation_good_flag(rg_flag), .o_skip_active(skip), .o_burst_active(burst),
    .o_low_power(low_pwr), .o_bulk_undervoltage_fault(bulk_uv));

  sdsg_downstream_model pm_u (
    .i_sys_clk(clk), .i_keep(keep), .i_width(width), .i_gap(gap), .o_pin_low(pin_low));

  // 100 MHz clock and a free cycle count
  always #5 clk = ~clk;
  always @(posedge clk) ncyc++;

  task automatic cyc(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // reset held 12 cycles; stimulus resumes at the third edge after release
  task automatic do_reset;
    rst_b = 1'h0;
    cyc(12);
    chk({main_drv, sync_drv, slow_drv, rg, rg_flag, skip, burst, bulk_uv}, 16'h0000);
    rst_b = 1'h1;
    cyc(3);
  endtask

  // one main pulse of random width, then count cycles from main low to sync high
  task automatic sync_try(input logic arm, input logic line);
    zarm = arm;
    line_ok = line;
    ztrig = 1'h1;
    main_req = 1'h1;
    n = 0;
    while (main_drv !== 1'h1 && n < 20) begin
      cyc();
      n++;
    end
    cyc(1 + $urandom_range(5));
    main_req = 1'h0;
    n = 0;
    while (main_drv !== 1'h0 && n < 20) begin
      cyc();
      n++;
    end
    dly = 0;
    while (sync_drv !== 1'h1 && dly < 40) begin
      cyc();
      dly++;
    end
  endtask

  // per-cycle model: drives exclusive, sync only after dead time and with the flag
  always @(negedge clk) begin
    if (rst_b === 1'h1 && (main_drv === 1'h1 || sync_drv === 1'h1)) begin
      chk(main_drv & sync_drv, 16'h0000);
    end
    if (sync_drv === 1'h1 && sync_q !== 1'h1) begin
      chk(main_low >= sdsg_pkg::DT1_CYCLES, 16'h0001);
      chk(rg_flag & ~skip, 16'h0001);
    end
    sync_q = sync_drv;
    main_low = (main_drv === 1'h1) ? 0 : main_low + 1;
  end

  // watchdog, far beyond the expected run of about 22000 cycles
  initial begin
    #800000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    {clk, main_req, slow_req, ccm, per_start, zarm, ztrig, line_ok} = 8'h00;
    {fb_ok, fb_exit, fb_nom, fb_low_bulk, fault, mod_low, keep} = 7'h00;
    per_len = 16'h0064;
    width = 16'h0BAE;
    gap = 16'h05DC;
    void'($urandom(72));
    do_reset();
    // before regulation: every drive, skip and undervoltage fault held off
    {main_req, slow_req, fb_low_bulk, line_ok, zarm, mod_low} = 6'h3F;
    cyc(3100);
    chk({main_drv, slow_drv, sync_drv, rg, skip, bulk_uv}, 16'h0000);
    {main_req, slow_req, fb_low_bulk, mod_low} = 4'h0;
    do_reset();
    $display("test startup done");
    fb_ok = 1'h1;
    cyc();
    chk({rg_flag, rg}, 16'h0003);
    fb_ok = 1'h0;
    fault = 1'h1;
    cyc(2);
    chk({rg_flag, rg}, 16'h0002);
    fault = 1'h0;
    {fb_low_bulk, slow_req} = 2'h3;
    cyc(3);
    chk({slow_drv, bulk_uv}, 16'h0003);
    {fb_low_bulk, slow_req} = 2'h0;
    cyc(3);
    $display("test regulation flag done");
    // sync with arm and line, without arm, without line
    for (int k = 0; k < 3; k++) begin
      sync_try(k != 1, k != 2);
      chk(16'(dly), (k == 0) ? 16'(sdsg_pkg::DT1_CYCLES + 2) : 16'h0028);
      ztrig = 1'h0;
      cyc(3);
    end
    // critical mode: main waits for the trigger crossing
    sync_try(1'h1, 1'h1);
    main_req = 1'h1;
    cyc(10);
    chk({main_drv, sync_drv}, 16'h0001);
    ztrig = 1'h0;
    cyc();
    chk(sync_drv, 16'h0000);
    cyc(3);
    chk(main_drv, 16'h0001);
    main_req = 1'h0;
    cyc(3);
    // with no sync pulse the main drive still waits for the trigger crossing
    sync_try(1'h0, 1'h1);
    main_req = 1'h1;
    cyc(5);
    chk(main_drv, 16'h0000);
    ztrig = 1'h0;
    cyc(3);
    chk(main_drv, 16'h0001);
    main_req = 1'h0;
    cyc(3);
    $display("test sync gating done");
    // continuous mode: sync cut ahead of the next period
    ccm = 1'h1;
    per_len = 16'(80 + $urandom_range(40));
    per_start = 1'h1;
    t0 = ncyc;
    cyc();
    per_start = 1'h0;
    sync_try(1'h1, 1'h1);
    cyc(int'(per_len) - 25 - (ncyc - t0));
    chk(sync_drv, 16'h0001);
    cyc(13);
    chk(sync_drv, 16'h0000);
    {ztrig, ccm} = 2'h0;
    cyc(3);
    $display("test continuous mode done");
    // pulses of exactly the minimum width are not longer than it, so ignored
    {main_req, slow_req} = 2'h3;
    width = 16'h0BB8;
    keep = 1'h1;
    cyc(4000);
    chk(skip, 16'h0000);
    keep = 1'h0;
    cyc(600);
    width = 16'h0BB9;
    keep = 1'h1;
    n = 0;
    while (skip !== 1'h1 && n < 3400) begin
      cyc();
      n++;
    end
    chk(n >= 3002, 16'h0001);
    chk({skip, low_pwr, rg, main_drv, sync_drv, slow_drv}, 16'h0038);
    // burst, skip again while commands come, then back to run
    fb_exit = 1'h1;
    cyc();
    fb_exit = 1'h0;
    cyc(4);
    chk({skip, burst, main_drv}, 16'h0003);
    cyc(4700);
    keep = 1'h0;
    cyc(3200);
    fb_nom = 1'h1;
    cyc(2);
    fb_nom = 1'h0;
    chk({skip, burst}, 16'h0002);
    fb_exit = 1'h1;
    cyc();
    fb_exit = 1'h0;
    cyc(2);
    fb_nom = 1'h1;
    cyc(2);
    fb_nom = 1'h0;
    chk({skip, burst}, 16'h0000);
    $display("test skip burst done");
    // command on the modulation pin
    mod_low = 1'h1;
    cyc(3100);
    mod_low = 1'h0;
    cyc(3);
    chk({skip, main_drv}, 16'h0002);
    $display("test second pin done");
    stop_test();
  end
endmodule
